// File: pkg/bmms_pkg.sv
// package of constants and carrier types for the boot memory map selector
//
// Summary of operation
// - read reset vector word before releasing core
// - programmed vector maps flash unless the boot pin forces rom, else boot rom
// - all-ones vector means unprogrammed, run loader
// - check reset vector, never the nmi word
// - port/pin fields name a forcing boot pin
package bmms_pkg;

   // ****************************************************************
   // flash addresses and values
   // ****************************************************************
   localparam logic [31:0] RESET_VECTOR_ADDR = 32'h0000_0004;
   localparam logic [31:0] NMI_VECTOR_ADDR = 32'h0000_0008;
   localparam logic [31:0] BASE_ADDR = 32'h0000_0000;
   localparam logic [31:0] ERASED_WORD = 32'hffff_ffff;

   // ****************************************************************
   // boot configuration register layout
   // ****************************************************************
   localparam int PORT_LSB = 13;
   localparam int PORT_W = 3;
   localparam int PIN_LSB = 10;
   localparam int PIN_W = 3;
   localparam int POL_BIT = 9;
   localparam int EN_BIT = 8;
   localparam logic [31:0] BOOT_CONFIG_RESET = 32'hffff_fffe;

   // ****************************************************************
   // timing
   // ****************************************************************
   // pin synchroniser fill time, counted after reset release
   localparam logic [3:0] SETTLE_CNT = 4'h2;
   localparam int CLOCK_MHZ = 25;
   localparam int FLASH_WAIT_NS = 40;
   localparam int FLASH_WAIT_CYC = (FLASH_WAIT_NS * CLOCK_MHZ + 999) / 1000;
   localparam logic [3:0] FLASH_WAIT_CNT = 4'(FLASH_WAIT_CYC < 1 ? 1 : FLASH_WAIT_CYC);

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic {MAP_ROM, MAP_FLASH} bmms_map_type;

   typedef struct packed {
      logic [31:0] addr;
      logic rd;
   } bmms_flash_req_type;

   typedef struct packed {
      bmms_map_type map;
      logic force_pin;
      logic vector_blank;
   } bmms_status_type;

endpackage

// File: design/bmms_sync.sv
// two flip-flop synchroniser for a bank of pin levels
`timescale 1ns/10ps
`default_nettype none
module bmms_sync #(
   parameter int W = 64
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] q_r;
   logic [W-1:0] q_nxt;

   // first stage only feeds second stage
   always_comb begin
      meta_nxt = d;
      q_nxt = meta_r;
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         meta_r <= '0;
         q_r <= '0;
      end else begin
         meta_r <= meta_nxt;
         q_r <= q_nxt;
      end
   end

   assign q = q_r;

endmodule
`default_nettype wire

// File: design/bmms_top.sv
// boot memory map selector: inspects reset vector, picks flash or rom at zero
`timescale 1ns/10ps
`default_nettype none
module bmms_top (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // boot configuration register contents, from nonvolatile store
   input wire logic [31:0] boot_config_register,
   // gpio pin levels, eight ports of eight pins
   input wire logic [63:0] gpio_pins,
   // flash read port
   output bmms_pkg::bmms_flash_req_type flash_req,
   input wire logic [31:0] flash_rdata,
   input wire logic flash_rvalid,
   // to core and memory decode
   output logic core_release,
   output bmms_pkg::bmms_map_type map_sel,
   output bmms_pkg::bmms_status_type boot_status
);

   // ****************************************************************
   // pin synchronisation
   // ****************************************************************
   logic [63:0] pins_s;

   bmms_sync #(
      .W(64)
   ) u_sync (
      .clock(clock),
      .resetn(resetn),
      .d(gpio_pins),
      .q(pins_s)
   );

   // ****************************************************************
   // sequencer
   // ****************************************************************
   typedef enum logic [2:0] {S_SETTLE, S_READ, S_WAIT, S_DECIDE, S_RUN} bmms_state_type;

   bmms_state_type state_r, state_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [31:0] vec_r, vec_nxt;
   bmms_pkg::bmms_flash_req_type req_r, req_nxt;
   logic release_r, release_nxt;
   bmms_pkg::bmms_map_type map_r, map_nxt;
   bmms_pkg::bmms_status_type stat_r, stat_nxt;
   logic [5:0] pin_idx;
   logic pin_level;
   logic force_boot;
   logic blank;
   logic to_rom;
   logic take_word;

   // selected forcing pin, chosen by port and pin fields
   // pin selection decode
   assign pin_idx = {boot_config_register[bmms_pkg::PORT_LSB +: bmms_pkg::PORT_W],
                     boot_config_register[bmms_pkg::PIN_LSB +: bmms_pkg::PIN_W]};
   assign pin_level = pins_s[pin_idx];
   // enable bit is active low, as an erased register keeps the feature off
   assign force_boot = !boot_config_register[bmms_pkg::EN_BIT] &&
                       (pin_level == boot_config_register[bmms_pkg::POL_BIT]);
   assign blank = (vec_r == bmms_pkg::ERASED_WORD);

   // ****************************************************************
   // shared decode
   // ****************************************************************
   // an early valid is ignored; the word counts only once the wait has run out
   assign take_word = (state_r == S_WAIT) && flash_rvalid && (cnt_r == 4'h0);
   // blank or forced goes to rom
   assign to_rom = blank || force_boot;

   // ****************************************************************
   // sequencer state and wait counter
   // ****************************************************************
   // next state and count
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      case (state_r)
         // give the pin synchroniser time to fill
         S_SETTLE: begin
            if (cnt_r == bmms_pkg::SETTLE_CNT) begin
               state_nxt = S_READ;
            end else begin
               cnt_nxt = cnt_r + 4'h1;
            end
         end
         S_READ: begin
            cnt_nxt = bmms_pkg::FLASH_WAIT_CNT;
            state_nxt = S_WAIT;
         end
         // access time first, then the answer
         S_WAIT: begin
            if (cnt_r != 4'h0) begin
               cnt_nxt = cnt_r - 4'h1;
            end
            if (take_word) begin
               state_nxt = S_DECIDE;
            end
         end
         // one cycle to judge the word
         S_DECIDE: begin
            state_nxt = S_RUN;
         end
         S_RUN: begin
            state_nxt = S_RUN;
         end
         default: begin
            state_nxt = S_SETTLE;
         end
      endcase
   end

   // only reset can leave the run state
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_r <= S_SETTLE;
         cnt_r <= 4'h0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // ****************************************************************
   // flash read request
   // ****************************************************************
   // strobe lasts one cycle; address stays put afterwards
   always_comb begin
      req_nxt = req_r;
      req_nxt.rd = 1'b0;
      if (state_r == S_READ) begin
         req_nxt.addr = bmms_pkg::RESET_VECTOR_ADDR;
         req_nxt.rd = 1'b1;
      end
   end

   // request register
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         req_r <= '0;
      end else begin
         req_r <= req_nxt;
      end
   end

   // ****************************************************************
   // vector capture
   // ****************************************************************
   // word kept so the decision sees a stable copy
   always_comb begin
      vec_nxt = vec_r;
      if (take_word) begin
         vec_nxt = flash_rdata;
      end
   end

   // vector register
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         vec_r <= 32'h0000_0000;
      end else begin
         vec_r <= vec_nxt;
      end
   end

   // ****************************************************************
   // mapping latch
   // ****************************************************************
   // written in the decision cycle only, so later pin or config changes are ignored
   always_comb begin
      map_nxt = map_r;
      stat_nxt = stat_r;
      if (state_r == S_DECIDE) begin
         if (to_rom) begin
            map_nxt = bmms_pkg::MAP_ROM;
            stat_nxt.map = bmms_pkg::MAP_ROM;
         end else begin
            map_nxt = bmms_pkg::MAP_FLASH;
            stat_nxt.map = bmms_pkg::MAP_FLASH;
         end
         stat_nxt.force_pin = force_boot;
         stat_nxt.vector_blank = blank;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         map_r <= bmms_pkg::MAP_ROM;
         stat_r <= '0;
      end else begin
         map_r <= map_nxt;
         stat_r <= stat_nxt;
      end
   end

   // ****************************************************************
   // core release
   // ****************************************************************
   // rises with the mapping, so the core never fetches from an undecided map
   always_comb begin
      release_nxt = release_r;
      if (state_r == S_DECIDE) begin
         release_nxt = 1'b1;
      end
   end

   // release register
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         release_r <= 1'b0;
      end else begin
         release_r <= release_nxt;
      end
   end

   assign flash_req = req_r;
   assign core_release = release_r;
   assign map_sel = map_r;
   assign boot_status = stat_r;

endmodule
`default_nettype wire

// File: sim/bmms_chk.sv
// assertion checker for the boot memory map selector
`timescale 1ns/10ps
`default_nettype none
module bmms_chk (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // flash read port
   input wire bmms_pkg::bmms_flash_req_type flash_req,
   input wire logic [31:0] flash_rdata,
   input wire logic flash_rvalid,
   // decision outputs
   input wire logic core_release,
   input wire bmms_pkg::bmms_map_type map_sel,
   input wire bmms_pkg::bmms_status_type boot_status
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   // read strobe, then word taken, then release two edges later
   sequence rd_pulse_s;
      flash_req.rd ##1 !flash_req.rd;
   endsequence
   sequence blank_s;
      flash_rvalid && flash_rdata == bmms_pkg::ERASED_WORD ##2 $rose(core_release);
   endsequence
   sequence prog_s;
      flash_rvalid && flash_rdata != bmms_pkg::ERASED_WORD ##2 $rose(core_release);
   endsequence
   rd_addr_a: assert property (flash_req.rd |-> flash_req.addr == bmms_pkg::RESET_VECTOR_ADDR)
      else $error("bad read address");
   rd_pulse_a: assert property (flash_req.rd |-> rd_pulse_s)
      else $error("read strobe too long");
   read_first_a: assert property ($rose(core_release) |-> $past(flash_rvalid, 2))
      else $error("release before read");
   blank_rom_a: assert property (blank_s |-> map_sel == bmms_pkg::MAP_ROM && boot_status.vector_blank)
      else $error("blank not rom");
   prog_map_a: assert property (prog_s |->
      !boot_status.vector_blank && map_sel == (boot_status.force_pin ? bmms_pkg::MAP_ROM : bmms_pkg::MAP_FLASH))
      else $error("wrong map");
   rom_early_a: assert property (!core_release |-> map_sel == bmms_pkg::MAP_ROM)
      else $error("map before release");
   map_hold_a: assert property (core_release |=> core_release && $stable(map_sel) && $stable(boot_status))
      else $error("map moved");
   one_read_a: assert property (core_release |-> !flash_req.rd && boot_status.map == map_sel)
      else $error("late read");
   force_rom_a: assert property (core_release && boot_status.force_pin |-> map_sel == bmms_pkg::MAP_ROM)
      else $error("forced pin not rom");
endmodule
bind bmms_top bmms_chk u_chk (.clock(clock), .resetn(resetn), .flash_req(flash_req), .flash_rdata(flash_rdata),
   .flash_rvalid(flash_rvalid), .core_release(core_release), .map_sel(map_sel), .boot_status(boot_status));
`default_nettype wire

// File: sim/bmms_flash.sv
// flash array model answering the one word read
`timescale 1ns/10ps
`default_nettype none
module bmms_flash (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // stored vector words and answer delay
   input wire logic [31:0] w_rst,
   input wire logic [31:0] w_nmi,
   input wire logic [3:0] dly,
   // read port
   input wire bmms_pkg::bmms_flash_req_type flash_req,
   output logic [31:0] flash_rdata,
   output logic flash_rvalid
);
   logic [3:0] cnt;
   logic [31:0] word;
   // data inverts every cycle outside valid, so a stale word matches only on every other cycle
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cnt <= 4'h0;
         flash_rvalid <= 1'b0;
         flash_rdata <= 32'h0;
      end else begin
         flash_rvalid <= cnt == 4'h1;
         flash_rdata <= cnt == 4'h1 ? word : ~flash_rdata;
         if (flash_req.rd) begin
            cnt <= dly;
            word <= flash_req.addr == 32'h0000_0004 ? w_rst : w_nmi;
         end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// File: sim/testbench.sv
// self-checking testbench for the boot memory map selector
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("wrong value %0t %h %h", $time, g, e); end end
module testbench;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [31:0] cfg = 32'hffff_fffe, w_rst = 32'h0, w_nmi = 32'h0, flash_rdata;
   logic [63:0] pins = 64'h0;
   logic [3:0] dly = 4'h1;
   logic flash_rvalid, core_release;
   bmms_pkg::bmms_flash_req_type flash_req;
   bmms_pkg::bmms_map_type map_sel;
   bmms_pkg::bmms_status_type boot_status;
   int n_mismatch = 0;
   int check_count = 0;
   initial forever #20 clock = ~clock;
   bmms_top dut (.clock(clock), .resetn(resetn), .boot_config_register(cfg), .gpio_pins(pins), .flash_req(flash_req),
      .flash_rdata(flash_rdata), .flash_rvalid(flash_rvalid), .core_release(core_release), .map_sel(map_sel),
      .boot_status(boot_status));
   bmms_flash flash (.clock(clock), .resetn(resetn), .w_rst(w_rst), .w_nmi(w_nmi), .dly(dly), .flash_req(flash_req),
      .flash_rdata(flash_rdata), .flash_rvalid(flash_rvalid));
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // reset mid-run, wait for release, judge, then disturb inputs
   task automatic boot(input logic [31:0] wr, wn, c, input logic [63:0] p, input logic [3:0] d,
      input bmms_pkg::bmms_map_type m, input logic bl, f);
      int i;
      @(posedge clock);
      resetn <= 1'b0;
      {w_rst, w_nmi, cfg, pins, dly} <= {wr, wn, c, p, d};
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      for (i = 0; i < 60 && core_release !== 1'b1; i++) @(negedge clock);
      `CHK(core_release, 1'b1)
      `CHK(map_sel, m)
      `CHK(boot_status.map, m)
      `CHK(boot_status.vector_blank, bl)
      `CHK(boot_status.force_pin, f)
      @(posedge clock);
      {w_rst, cfg, pins} <= {~wr, ~c, ~p};
      repeat (8) @(negedge clock);
      `CHK(map_sel, m)
      `CHK(core_release, 1'b1)
      `CHK(boot_status.force_pin, f)
      `CHK(boot_status.vector_blank, bl)
   endtask
   task automatic t_nmi_blank;
      boot(32'h0000_0101, 32'hffff_ffff, 32'hffff_fffe, 64'h0, 4'h1, bmms_pkg::MAP_FLASH, 1'b0, 1'b0);
   endtask
   task automatic t_vec_blank;
      boot(32'hffff_ffff, 32'h0000_0201, 32'hffff_fffe, 64'h0, 4'h3, bmms_pkg::MAP_ROM, 1'b1, 1'b0);
   endtask
   task automatic t_pin_force;
      boot(32'h0000_0301, 32'h0000_0301, 32'h0000_4e00, 64'h8_0000, 4'h6, bmms_pkg::MAP_ROM, 1'b0, 1'b1);
   endtask
   task automatic t_pin_idle;
      boot(32'h0000_0401, 32'h0000_0401, 32'h0000_4c00, 64'h8_0000, 4'h2, bmms_pkg::MAP_FLASH, 1'b0, 1'b0);
   endtask
   initial begin
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      t_nmi_blank();
      t_vec_blank();
      t_pin_force();
      t_pin_idle();
      stop_test();
   end
   // hang guard sized well past four boots
   initial begin
      repeat (2000) @(posedge clock);
      n_mismatch++;
      stop_test();
   end
endmodule
`default_nettype wire
